// [core/lpcu_low_power_counter_unit.sv]
// Low-power 16-bit time/pulse counter with compare and AXI4-Lite registers
// Function
// - Compare counter with 16-bit compare value; equality raises interrupt, may reset.
// - Two personalities: time counter via prescaler, pulse counter via filter.
// - Time mode divides by power of two; pulse mode uses stage as filter.
// - Input select 00 comparator, 01..11 alternate pins one to three.
// - Clock select 00 internal, 01 1 kHz, 10 32 kHz, 11 external.
// - Counts normally in run, wait, stop, low leakage; interrupt wakes.
// - Enabled interrupt also drives wakeup; flag sets only while the bus clock runs.
// - Debug halt freezes time mode; pulse mode keeps counting.
// - Active-high polarity: input assertion increments counter by one.
// - Active-low polarity: input assertion, a falling edge, increments counter by one.
// - Pulse inputs are asynchronous and synchronised before use.
// - Counter runs freely or returns to zero on compare match.
// - Counting state survives system resets; only own reset or clearing enable clears it.
// - Flag sets on enabled match-and-increment; clears on disable or W1C.
// - Clearing enable disables counter and resets count, divider/filter stage, trigger and flag.
// - Free bit clear: reset on flag set; set: reset only on overflow.
// - Prescale 0 divides by 2, doubling per code; filter needs half.
`timescale 1ns/1ps
`include "lpcu_regs.svh"
module lpcu_low_power_counter_unit #(
    parameter int COUNT_WIDTH = 16
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic [31:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [31:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic internal_reference_clock_i,
    input wire logic low_power_oscillator_clock_i,
    input wire logic slow_external_clock_i,
    input wire logic external_reference_clock_i,
    input wire logic analog_comparator_zero_i,
    input wire logic [2:0] alternate_pulse_pin_i,
    input wire logic debug_halt_i,
    output logic irq_o,
    output logic wakeup_o,
    output logic trigger_o,
    output logic [COUNT_WIDTH-1:0] count_value_o
);
    // Control fields
    logic counter_enable;
    lpcu_pkg::lpcu_mode_type mode;
    logic free_running_select;
    logic pulse_polarity_select;
    logic [1:0] pulse_input_select;
    logic match_interrupt_enable;
    logic compare_match_flag;
    logic [1:0] counter_clock_select;
    logic prescale_bypass;
    logic [3:0] prescale;
    logic [COUNT_WIDTH-1:0] compare_value;
    logic [COUNT_WIDTH-1:0] count_value;

    // Bus slave state
    // One write in flight; each half is held until the response
    logic aw_held, w_held;
    logic [3:0] aw_ofs;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // Synchronisers: four counter clocks and four pulse sources
    // Clocks are sampled as data; each level must last two cycles
    logic [3:0] raw_in, s1, s2;
    logic src_prev;
    assign raw_in = {alternate_pulse_pin_i, analog_comparator_zero_i};
    logic [3:0] clk_in, c1, c2;
    assign clk_in = {external_reference_clock_i, slow_external_clock_i,
                     low_power_oscillator_clock_i,
                     internal_reference_clock_i};
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sync
            always_ff @(posedge clock_i) begin
                s1[g] <= raw_in[g];
                s2[g] <= s1[g];
                c1[g] <= clk_in[g];
                c2[g] <= c1[g];
            end
        end
    endgenerate

    // Prescaler clock edge from the selected source
    wire sel_clk = c2[counter_clock_select];
    wire tick = sel_clk & ~src_prev;
    // No reset needed: tracks its input within one cycle
    always_ff @(posedge clock_i) begin
        src_prev <= sel_clk;
    end

    // Pulse source selection and polarity
    wire pulse_raw = s2[pulse_input_select] ^ pulse_polarity_select;

    // Prescaler divider and glitch filter share one counter
    logic [15:0] stage_cnt;
    logic filt_level;
    wire [15:0] div_last = 16'((32'd2 << prescale) - 32'd1);
    wire [15:0] filt_last = (prescale == 4'h0) ? 16'h0000
        : 16'((32'd1 << prescale) - 32'd1);
    wire time_inc = (mode == lpcu_pkg::LPCU_TIME_MODE) && tick
        && !debug_halt_i && (prescale_bypass
        || stage_cnt == div_last);
    // Any bounce inside the window restarts the filter count
    wire filt_differs = pulse_raw != filt_level;
    wire filt_next = prescale_bypass ? pulse_raw
        : ((filt_differs && tick && stage_cnt == filt_last)
           ? pulse_raw : filt_level);
    wire pulse_inc = (mode == lpcu_pkg::LPCU_PULSE_MODE)
        && filt_next && !filt_level;
    wire inc = counter_enable && (time_inc || pulse_inc);
    wire match = inc && (count_value == compare_value);
    // Wraps to zero past all ones when free-running
    wire [COUNT_WIDTH-1:0] next_count = count_value + COUNT_WIDTH'(1);

    // Debug halt freezes the divider too, keeping the partial period
    always_ff @(posedge clock_i) begin
        // Bus clock reset only; system resets are not wired in here
        if (srst_i || !counter_enable) begin
            stage_cnt <= 16'h0000;
            filt_level <= 1'b0;
        end else if (mode == lpcu_pkg::LPCU_TIME_MODE) begin
            if (tick && !debug_halt_i && !prescale_bypass)
                stage_cnt <= (stage_cnt == div_last) ? 16'h0000
                    : stage_cnt + 16'h0001;
        end else begin
            filt_level <= filt_next;
            if (!filt_differs || prescale_bypass)
                stage_cnt <= 16'h0000;
            else if (tick)
                stage_cnt <= (stage_cnt == filt_last) ? 16'h0000
                    : stage_cnt + 16'h0001;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i || !counter_enable) begin
            count_value <= '0;
        end else if (inc) begin
            if (match && !free_running_select)
                count_value <= '0;
            else
                count_value <= next_count;
        end
    end

    // Trigger holds until the next prescaler clock edge
    always_ff @(posedge clock_i) begin
        if (srst_i || !counter_enable)
            trigger_o <= 1'b0;
        else if (match)
            trigger_o <= 1'b1;
        else if (tick)
            trigger_o <= 1'b0;
    end

    // Level straight from flops so it works with bus clock gated
    assign irq_o = compare_match_flag & match_interrupt_enable;
    assign wakeup_o = irq_o;
    assign count_value_o = count_value;

    // AXI4-Lite write path
    wire aw_take = s_axi_awvalid_i & ~aw_held & ~s_axi_bvalid_o;
    wire w_take = s_axi_wvalid_i & ~w_held & ~s_axi_bvalid_o;
    assign s_axi_awready_o = ~aw_held & ~s_axi_bvalid_o;
    assign s_axi_wready_o = ~w_held & ~s_axi_bvalid_o;
    wire do_write = aw_held & w_held;
    wire wr_csr = do_write && aw_ofs == `LPCU_OFS_CTRL_STATUS && w_strb[0];
    wire wr_psr = do_write && aw_ofs == `LPCU_OFS_PRESCALE && w_strb[0];
    // Compare ignores byte strobes; count writes are dropped
    wire wr_cmp = do_write && aw_ofs == `LPCU_OFS_COMPARE;
    wire wr_ok = aw_ofs == `LPCU_OFS_CTRL_STATUS
        || aw_ofs == `LPCU_OFS_PRESCALE
        || aw_ofs == `LPCU_OFS_COMPARE || aw_ofs == `LPCU_OFS_COUNT;
    wire next_enable = wr_csr ? w_data[`LPCU_CSR_ENABLE] : counter_enable;
    wire flag_w1c = wr_csr && w_data[`LPCU_CSR_FLAG];

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_ofs <= 4'h0;
            w_data <= `LPCU_RESET_WORD;
            w_strb <= 4'h0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `LPCU_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_ofs <= {s_axi_awaddr_i[3:2], 2'b00};
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata_i;
                w_strb <= s_axi_wstrb_i;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= wr_ok ? `LPCU_RESP_OKAY
                    : `LPCU_RESP_SLVERR;
            end else if (s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    // Control and prescale settings live in byte lane zero only; compare takes bits 15:0 whatever the strobes
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            counter_enable <= 1'b0;
            mode <= lpcu_pkg::LPCU_TIME_MODE;
            free_running_select <= 1'b0;
            pulse_polarity_select <= 1'b0;
            pulse_input_select <= 2'b00;
            match_interrupt_enable <= 1'b0;
            counter_clock_select <= 2'b00;
            prescale_bypass <= 1'b0;
            prescale <= 4'h0;
            compare_value <= '0;
        end else begin
            if (wr_csr) begin
                counter_enable <= w_data[`LPCU_CSR_ENABLE];
                mode <= lpcu_pkg::lpcu_mode_type'(w_data[`LPCU_CSR_MODE]);
                free_running_select <= w_data[`LPCU_CSR_FREE];
                pulse_polarity_select <= w_data[`LPCU_CSR_POL];
                pulse_input_select <= w_data[`LPCU_CSR_PSEL_LO +: 2];
                match_interrupt_enable <= w_data[`LPCU_CSR_IE];
            end
            if (wr_psr) begin
                counter_clock_select <= w_data[`LPCU_PSR_CSEL_LO +: 2];
                prescale_bypass <= w_data[`LPCU_PSR_BYPASS];
                prescale <= w_data[`LPCU_PSR_PRE_LO +: 4];
            end
            if (wr_cmp)
                compare_value <= w_data[COUNT_WIDTH-1:0];
        end
    end

    // Set wins over a same-cycle one-to-clear
    always_ff @(posedge clock_i) begin
        if (srst_i || !next_enable || !counter_enable)
            compare_match_flag <= 1'b0;
        else if (match)
            compare_match_flag <= 1'b1;
        else if (flag_w1c)
            compare_match_flag <= 1'b0;
    end

    // AXI4-Lite read path
    // Only bits 3:2 decode, so the four words repeat upward
    wire [3:0] ar_ofs = {s_axi_araddr_i[3:2], 2'b00};
    wire [31:0] csr_word = {24'h00_0000, compare_match_flag,
        match_interrupt_enable, pulse_input_select, pulse_polarity_select,
        free_running_select, mode, counter_enable};
    wire [31:0] psr_word = {25'h000_0000, prescale, prescale_bypass,
        counter_clock_select};
    wire [31:0] cmp_word = 32'(compare_value);
    wire [31:0] cnt_word = 32'(count_value);
    wire rd_ok = ar_ofs == `LPCU_OFS_CTRL_STATUS
        || ar_ofs == `LPCU_OFS_PRESCALE
        || ar_ofs == `LPCU_OFS_COMPARE || ar_ofs == `LPCU_OFS_COUNT;
    wire [31:0] rd_word =
        (ar_ofs == `LPCU_OFS_CTRL_STATUS) ? csr_word :
        (ar_ofs == `LPCU_OFS_PRESCALE) ? psr_word :
        (ar_ofs == `LPCU_OFS_COMPARE) ? cmp_word :
        (ar_ofs == `LPCU_OFS_COUNT) ? cnt_word : `LPCU_RESET_WORD;
    assign s_axi_arready_o = ~s_axi_rvalid_o;
    // Read data is captured at acceptance and held until taken

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= `LPCU_RESET_WORD;
            s_axi_rresp_o <= `LPCU_RESP_OKAY;
        end else if (s_axi_arvalid_i && !s_axi_rvalid_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= rd_word;
            s_axi_rresp_o <= rd_ok ? `LPCU_RESP_OKAY : `LPCU_RESP_SLVERR;
        end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end
endmodule

// [shared/lpcu_regs.svh]
// Register offsets, field positions and reset values of the counter unit
`ifndef LPCU_REGS_SVH
`define LPCU_REGS_SVH
`define LPCU_OFS_CTRL_STATUS 4'h0
`define LPCU_OFS_PRESCALE 4'h4
`define LPCU_OFS_COMPARE 4'h8
`define LPCU_OFS_COUNT 4'hC
`define LPCU_CSR_ENABLE 0
`define LPCU_CSR_MODE 1
`define LPCU_CSR_FREE 2
`define LPCU_CSR_POL 3
`define LPCU_CSR_PSEL_LO 4
`define LPCU_CSR_IE 6
`define LPCU_CSR_FLAG 7
`define LPCU_PSR_CSEL_LO 0
`define LPCU_PSR_BYPASS 2
`define LPCU_PSR_PRE_LO 3
`define LPCU_RESP_OKAY 2'b00
`define LPCU_RESP_SLVERR 2'b10
`define LPCU_RESET_WORD 32'h0000_0000
`endif

// [shared/lpcu_pkg.sv]
// Types shared by the counter unit
package lpcu_pkg;
    typedef enum logic {
        LPCU_TIME_MODE,
        LPCU_PULSE_MODE
    } lpcu_mode_type;
    typedef logic [15:0] lpcu_count_type;
endpackage

// [verification/lpcu_far_model.sv]
// Far-side model: counter clocks and pulse sources
`timescale 1ns/1ps
module lpcu_far_model (
    input wire logic clock_i,
    output logic [3:0] cc_o = 4'h0,
    output logic [3:0] src_o = 4'h0
);
    // Selected clock kept alive in bursts only
    // Halves of 4 bus cycles, long enough for the sampler
    task automatic burst(input int k, input int n);
        repeat (n) begin
            repeat (4) @(posedge clock_i);
            cc_o <= cc_o | (4'h1 << k);
            repeat (4) @(posedge clock_i);
            cc_o <= cc_o & ~(4'h1 << k);
        end
    endtask
    // Level change with no tie to any bus transfer
    task automatic level(input int s, input logic v);
        @(posedge clock_i);
        src_o <= (src_o & ~(4'h1 << s)) | (4'(v) << s);
        repeat (4) @(posedge clock_i);
    endtask
endmodule

// [verification/lpcu_low_power_counter_unit_chk.sv]
// Port checker for the counter unit
`timescale 1ns/1ps
module lpcu_low_power_counter_unit_chk #(
    parameter int COUNT_WIDTH = 16
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_rvalid_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic irq_o,
    input wire logic wakeup_o,
    input wire logic trigger_o,
    input wire logic [COUNT_WIDTH-1:0] count_value_o
);
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (srst_i);
    // Register writes land within a cycle of the response
    sequence s_resp_near;
        ($past(s_axi_bvalid_o) || s_axi_bvalid_o) or (1'h1 ##1 s_axi_bvalid_o);
    endsequence
    sequence s_trig_near;
        1'h1 ##[0:1] trigger_o;
    endsequence
    irq_wake_a: assert property (irq_o == wakeup_o)
        else $error("wakeup differs from irq");
    count_step_a: assert property ($changed(count_value_o) |->
        count_value_o == $past(count_value_o) + 1'h1 || ~|count_value_o)
        else $error("count jumped");
    trig_count_a: assert property ($rose(trigger_o) |->
        $past(count_value_o) != count_value_o ||
        $past(count_value_o, 2) != $past(count_value_o))
        else $error("trigger without increment");
    reset_clear_a: assert property ($fell(srst_i) |-> ~|count_value_o &&
        !irq_o && !trigger_o && !s_axi_bvalid_o)
        else $error("state left after reset");
    irq_fall_a: assert property ($fell(irq_o) |-> s_resp_near)
        else $error("irq dropped with no write");
    irq_rise_a: assert property ($rose(irq_o) |-> s_resp_near or s_trig_near)
        else $error("irq rose with no cause");
    zero_cause_a: assert property ($changed(count_value_o) && ~|count_value_o
        && !(&$past(count_value_o)) |-> s_trig_near or s_resp_near)
        else $error("count cleared with no cause");
    rdata_high_a: assert property (s_axi_rvalid_o |->
        s_axi_rdata_o[31:16] == 16'h0000)
        else $error("upper read bits not zero");
endmodule
bind lpcu_low_power_counter_unit lpcu_low_power_counter_unit_chk #(
    .COUNT_WIDTH(COUNT_WIDTH)) chk_u (.clock_i(clock_i), .srst_i(srst_i),
    .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rdata_o(s_axi_rdata_o), .irq_o(irq_o), .wakeup_o(wakeup_o),
    .trigger_o(trigger_o), .count_value_o(count_value_o));

// [verification/lpcu_low_power_counter_unit_bench.sv]
// Self-checking bench for the counter unit
`timescale 1ns/1ps
`include "lpcu_regs.svh"
module lpcu_low_power_counter_unit_bench;
    logic clock_i = 1'h0;
    logic srst_i = 1'h1;
    logic [31:0] awaddr = 32'h0000_0000, wdata = 32'h0000_0000;
    logic [31:0] araddr = 32'h0000_0000;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0, dbg = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, irq, wake, trig;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] cnt;
    logic [3:0] cc, src;
    int mismatches = 0;
    int samples_checked = 0;
    always #2 clock_i = ~clock_i;
    lpcu_far_model partner_u (.clock_i(clock_i), .cc_o(cc), .src_o(src));
    lpcu_low_power_counter_unit dut_u (.clock_i(clock_i), .srst_i(srst_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .internal_reference_clock_i(cc[0]),
        .low_power_oscillator_clock_i(cc[1]), .slow_external_clock_i(cc[2]),
        .external_reference_clock_i(cc[3]), .analog_comparator_zero_i(src[0]),
        .alternate_pulse_pin_i(src[3:1]), .debug_halt_i(dbg), .irq_o(irq),
        .wakeup_o(wake), .trigger_o(trig), .count_value_o(cnt));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic done;
        done = 1'h0;
        @(posedge clock_i);
        awaddr <= {28'h000_0000, a};
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        while (!done) begin
            @(posedge clock_i);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid) begin
                done = 1'h1;
                bready <= 1'h0;
            end
        end
        repeat (2) @(posedge clock_i);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        logic done;
        done = 1'h0;
        @(posedge clock_i);
        araddr <= {28'h000_0000, a};
        {arvalid, rready} <= 2'h3;
        while (!done) begin
            @(posedge clock_i);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid) begin
                done = 1'h1;
                rready <= 1'h0;
                chk(rdata, exp);
            end
        end
    endtask
    // Active-low idle sits high, so a pulse dips low then returns
    task automatic pulse(input int s, input logic p);
        partner_u.level(s, !p);
        partner_u.level(s, p);
    endtask
    task automatic run(input int k, input int n);
        partner_u.burst(k, n);
        repeat (8) @(posedge clock_i);
    endtask
    initial begin
        repeat (12) @(posedge clock_i);
        srst_i <= 1'h0;
        for (int i = 0; i < 4; i++) rd(4'(i * 4), 32'h0000_0000);
        wr(`LPCU_OFS_COMPARE, 32'h0000_FFFF);
        for (int k = 0; k < 4; k++) begin
            wr(`LPCU_OFS_PRESCALE, 32'(k) | 32'h0000_0004);
            wr(`LPCU_OFS_CTRL_STATUS, 32'h0000_0001);
            run((k + 1) % 4, 3);
            run(k, k + 2);
            chk(32'(cnt), 32'(k + 2));
            wr(`LPCU_OFS_CTRL_STATUS, 32'h0000_0000);
            chk(32'(cnt), 32'h0000_0000);
        end
        for (int p = 0; p < 2; p++) begin
            wr(`LPCU_OFS_PRESCALE, 32'h0000_0001 | 32'(p << 3));
            wr(`LPCU_OFS_CTRL_STATUS, 32'h0000_0001);
            run(1, 8);
            chk(32'(cnt), 32'(8 >> (p + 1)));
            wr(`LPCU_OFS_CTRL_STATUS, 32'h0000_0000);
        end
        wr(`LPCU_OFS_PRESCALE, 32'h0000_0004);
        wr(`LPCU_OFS_CTRL_STATUS, 32'h0000_0001);
        dbg <= 1'h1;
        run(0, 3);
        chk(32'(cnt), 32'h0000_0000);
        wr(`LPCU_OFS_CTRL_STATUS, 32'h0000_0003);
        pulse(0, 1'h0);
        pulse(0, 1'h0);
        chk(32'(cnt), 32'h0000_0002);
        dbg <= 1'h0;
        for (int m = 0; m < 8; m++) begin
            wr(`LPCU_OFS_CTRL_STATUS, 32'h0000_0000);
            partner_u.level(m % 4, 1'(m / 4));
            wr(`LPCU_OFS_CTRL_STATUS, 32'(3 | (m / 4) << 3 | (m % 4) << 4));
            pulse(m % 4, 1'(m / 4));
            pulse((m + 1) % 4, 1'(m / 4));
            pulse(m % 4, 1'(m / 4));
            chk(32'(cnt), 32'h0000_0002);
        end
        wr(`LPCU_OFS_CTRL_STATUS, 32'h0000_0000);
        // Glitch filter: two ticks of steady change are needed
        wr(`LPCU_OFS_PRESCALE, 32'h0000_0009);
        wr(`LPCU_OFS_CTRL_STATUS, 32'h0000_000B);
        partner_u.level(0, 1'h0);
        run(1, 1);
        partner_u.level(0, 1'h1);
        run(1, 2);
        chk(32'(cnt), 32'h0000_0000);
        partner_u.level(0, 1'h0);
        run(1, 2);
        partner_u.level(0, 1'h1);
        run(1, 2);
        chk(32'(cnt), 32'h0000_0001);
        // Own reset in mid-run clears count and settings
        srst_i <= 1'h1;
        repeat (4) @(posedge clock_i);
        srst_i <= 1'h0;
        rd(`LPCU_OFS_CTRL_STATUS, 32'h0000_0000);
        rd(`LPCU_OFS_PRESCALE, 32'h0000_0000);
        chk(32'(cnt), 32'h0000_0000);
        wr(`LPCU_OFS_PRESCALE, 32'h0000_0004);
        wr(`LPCU_OFS_COMPARE, 32'hABCD_0003);
        rd(`LPCU_OFS_COMPARE, 32'h0000_0003);
        wr(`LPCU_OFS_CTRL_STATUS, 32'h0000_0041);
        run(0, 4);
        chk({cnt, 13'h0000, irq, wake, trig}, 32'h0000_0007);
        rd(`LPCU_OFS_CTRL_STATUS, 32'h0000_00C1);
        wr(`LPCU_OFS_CTRL_STATUS, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0000);
        rd(`LPCU_OFS_CTRL_STATUS, 32'h0000_0081);
        wr(`LPCU_OFS_CTRL_STATUS, 32'h0000_00C1);
        rd(`LPCU_OFS_CTRL_STATUS, 32'h0000_0041);
        wr(`LPCU_OFS_CTRL_STATUS, 32'h0000_0045);
        run(0, 5);
        wr(`LPCU_OFS_COUNT, 32'h0000_1234);
        chk({cnt, 15'h0000, irq}, 32'h0005_0001);
        wr(`LPCU_OFS_CTRL_STATUS, 32'h0000_0000);
        chk({cnt, 15'h0000, irq}, 32'h0000_0000);
        rd(`LPCU_OFS_CTRL_STATUS, 32'h0000_0000);
        give_verdict;
    end
    initial begin
        #200000;
        mismatches++;
        give_verdict;
    end
endmodule
